// file: logic/iedd_top.v
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "iedd_defs.vh"

// Functional notes
// - threshold is unsigned 0..127 at 0.063 g
// - compare range reaches 8 g only at 8 g full scale with low-noise off
// - low-noise caps threshold at 4 g
// - clear mode zeroes counter when false
// - decrement mode lowers counter, stops at zero
// - flag set when counter equals count value
// - counter saturates at the count value
// - step equals rate period, with mode exceptions
// - low-power modes stretch step to 80/160 ms
// - bypass bit selects unfiltered transient samples
// - per-axis enables gate transient events
// - latch mode freezes status once active
// - source read clears every source bit
// - new events may add bits while active, unless latch mode is on
// - event bits stay set until read
// - active flag is OR of enabled events
// - polarity bit one means negative acceleration
// - motion is any-above, freefall all-at-or-below
// - transient compares unsigned magnitude to threshold

module iedd_top #(
  parameter ADDR_W = 10,
  parameter STEP_BASE_CYCLES = `IEDD_STEP_BASE_NS / `IEDD_CLK_PERIOD_NS,
  parameter STEP_CNT_W = 25,
  parameter SAMPLE_W = 14
) (
  input wire clock,
  input wire rst_b,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire sample_valid,
  input wire [SAMPLE_W-1:0] accel_x,
  input wire [SAMPLE_W-1:0] accel_y,
  input wire [SAMPLE_W-1:0] accel_z,
  input wire [SAMPLE_W-1:0] hpf_x,
  input wire [SAMPLE_W-1:0] hpf_y,
  input wire [SAMPLE_W-1:0] hpf_z,
  output wire motion_event,
  output wire transient_event
);

  // ********************************************************
  // helper functions
  // ********************************************************

  // magnitude in 1/16 g counts; 8 g full scale gives 128
  function [7:0] iedd_mag;
    input [SAMPLE_W-1:0] s;
    input [1:0] fs;
    reg [SAMPLE_W-1:0] a;
    reg [SAMPLE_W-1:0] sh;
    begin
      a = s[SAMPLE_W-1] ? (~s + 1'b1) : s;
      case (fs)
        `IEDD_FS_2G: sh = a >> 8;
        `IEDD_FS_4G: sh = a >> 7;
        default: sh = a >> 6;
      endcase
      iedd_mag = sh[7:0];
    end
  endfunction

  // low-noise limits the reachable threshold to 4 g
  function [6:0] iedd_cap;
    input [6:0] ths;
    input ln;
    begin
      if (ln && (ths > `IEDD_THS_LN_CAP)) begin
        iedd_cap = `IEDD_THS_LN_CAP;
      end else begin
        iedd_cap = ths;
      end
    end
  endfunction

  // ********************************************************
  // register state
  // ********************************************************
  reg [7:0] mot_ths_q;
  reg [7:0] mot_cnt_q;
  reg [4:0] tr_cfg_q;
  reg [7:0] ctrl_q;
  reg [3:0] mode_q;
  reg [3:0] mot_axis_q;
  reg [6:0] tr_ths_q;
  reg [2:0] tr_ev_q;
  reg [2:0] tr_pol_q;
  reg [2:0] tr_ev_d;
  reg [2:0] tr_pol_d;
  reg mot_cond_q;
  reg pslverr_q;
  reg [31:0] rd_d;
  reg err_d;
  wire [7:0] mot_dbc_cnt;

  wire [7:0] idx = paddr[9:2];
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr_en = ce & access & pwrite;
  wire rd_src = ce & access & ~pwrite & (idx == `IEDD_IDX_TR_SRC);

  wire [2:0] tr_en = tr_cfg_q[3:1];
  wire latch_en = tr_cfg_q[`IEDD_TCFG_LATCH_BIT];
  wire bypass = tr_cfg_q[`IEDD_TCFG_BYP_BIT];
  wire low_noise = ctrl_q[`IEDD_CTRL_LN_BIT];
  wire [2:0] output_data_rate = ctrl_q[`IEDD_CTRL_ODR_LSB+2:`IEDD_CTRL_ODR_LSB];
  wire [1:0] os_mode = mode_q[1:0];
  wire [1:0] fs = mode_q[`IEDD_MODE_FS_LSB+1:`IEDD_MODE_FS_LSB];
  wire [2:0] mot_en = mot_axis_q[2:0];
  wire mot_or = mot_axis_q[`IEDD_AXIS_OR_BIT];

  // ********************************************************
  // apb slave
  // ********************************************************
  // zero wait states: read data is caught in the setup cycle
  assign pready = access & ce;
  assign pslverr = access & pslverr_q;

  always @* begin
    rd_d = `IEDD_RST_WORD;
    err_d = 1'b0;
    case (idx)
      `IEDD_IDX_MOT_THS: rd_d[7:0] = mot_ths_q;
      `IEDD_IDX_MOT_CNT: rd_d[7:0] = mot_cnt_q;
      `IEDD_IDX_TR_CFG: rd_d[4:0] = tr_cfg_q;
      `IEDD_IDX_TR_SRC: begin
        rd_d[`IEDD_TSRC_EA_BIT] = transient_event;
        rd_d[5:0] = {tr_ev_q[2], tr_pol_q[2], tr_ev_q[1], tr_pol_q[1],
                     tr_ev_q[0], tr_pol_q[0]};
      end
      `IEDD_IDX_CTRL: rd_d[7:0] = ctrl_q;
      `IEDD_IDX_MODE: rd_d[3:0] = mode_q;
      `IEDD_IDX_MOT_AXIS: rd_d[3:0] = mot_axis_q;
      `IEDD_IDX_TR_THS: rd_d[6:0] = tr_ths_q;
      `IEDD_IDX_MOT_STAT: begin
        rd_d[`IEDD_STAT_FLAG_BIT] = motion_event;
        rd_d[7:0] = mot_dbc_cnt;
      end
      default: err_d = 1'b1;
    endcase
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= `IEDD_RST_WORD;
      pslverr_q <= 1'b0;
    end else if (ce && setup) begin
      prdata <= pwrite ? `IEDD_RST_WORD : rd_d;
      pslverr_q <= err_d;
    end
  end

  // writes land at the access edge; read-only and unmapped are ignored
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mot_ths_q <= `IEDD_RST_BYTE;
      mot_cnt_q <= `IEDD_RST_BYTE;
      tr_cfg_q <= 5'h00;
      ctrl_q <= `IEDD_RST_BYTE;
      mode_q <= 4'h0;
      mot_axis_q <= 4'h0;
      tr_ths_q <= 7'h00;
    end else if (wr_en) begin
      case (idx)
        `IEDD_IDX_MOT_THS: mot_ths_q <= pwdata[7:0];
        `IEDD_IDX_MOT_CNT: mot_cnt_q <= pwdata[7:0];
        `IEDD_IDX_TR_CFG: tr_cfg_q <= pwdata[4:0];
        `IEDD_IDX_CTRL: ctrl_q <= pwdata[7:0];
        `IEDD_IDX_MODE: mode_q <= pwdata[3:0];
        `IEDD_IDX_MOT_AXIS: mot_axis_q <= pwdata[3:0];
        `IEDD_IDX_TR_THS: tr_ths_q <= pwdata[6:0];
        default: mot_ths_q <= mot_ths_q;
      endcase
    end
  end

  // ********************************************************
  // freefall and motion condition
  // ********************************************************
  wire [6:0] mot_thr = iedd_cap(mot_ths_q[6:0], low_noise);
  wire [2:0] mot_above;
  assign mot_above[0] = iedd_mag(accel_x, fs) > {1'b0, mot_thr};
  assign mot_above[1] = iedd_mag(accel_y, fs) > {1'b0, mot_thr};
  assign mot_above[2] = iedd_mag(accel_z, fs) > {1'b0, mot_thr};

  wire mot_any = |(mot_en & mot_above);
  wire ff_all = &(~mot_en | ~mot_above);

  // condition is held between samples so the step sees the latest one
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mot_cond_q <= 1'b0;
    end else if (ce && sample_valid) begin
      mot_cond_q <= mot_or ? mot_any : ff_all;
    end
  end

  // ********************************************************
  // debounce stepping and counter
  // ********************************************************
  wire step;

  iedd_step_timer #(
    .BASE_CYCLES(STEP_BASE_CYCLES),
    .CNT_W(STEP_CNT_W)
  ) u_step (
    .clock(clock),
    .rst_b(rst_b),
    .ce(ce),
    .output_data_rate(output_data_rate),
    .mode(os_mode),
    .step_q(step)
  );

  iedd_debounce #(
    .W(8)
  ) u_dbc (
    .clock(clock),
    .rst_b(rst_b),
    .ce(ce),
    .step(step),
    .cond(mot_cond_q),
    .clear_mode(mot_ths_q[`IEDD_THS_MODE_BIT]),
    .limit(mot_cnt_q),
    .cnt_q(mot_dbc_cnt),
    .flag_q(motion_event)
  );

  // ********************************************************
  // transient detection
  // ********************************************************
  wire [SAMPLE_W-1:0] tx = bypass ? accel_x : hpf_x;
  wire [SAMPLE_W-1:0] ty = bypass ? accel_y : hpf_y;
  wire [SAMPLE_W-1:0] tz = bypass ? accel_z : hpf_z;
  wire [6:0] tr_thr = iedd_cap(tr_ths_q, low_noise);
  wire [2:0] tr_over;
  assign tr_over[0] = iedd_mag(tx, fs) > {1'b0, tr_thr};
  assign tr_over[1] = iedd_mag(ty, fs) > {1'b0, tr_thr};
  assign tr_over[2] = iedd_mag(tz, fs) > {1'b0, tr_thr};
  wire [2:0] tr_sign = {tz[SAMPLE_W-1], ty[SAMPLE_W-1], tx[SAMPLE_W-1]};
  wire [2:0] tr_hit = {3{sample_valid}} & tr_en & tr_over;

  assign transient_event = |(tr_ev_q & tr_en);
  // a read releases the freeze, so an event on the read edge survives
  wire frozen = latch_en & transient_event & ~rd_src;

  always @* begin
    tr_ev_d = tr_ev_q;
    tr_pol_d = tr_pol_q;
    if (rd_src) begin
      tr_ev_d = 3'h0;
      tr_pol_d = 3'h0;
    end
    if (!frozen) begin
      tr_ev_d = tr_ev_d | tr_hit;
      tr_pol_d = (tr_pol_d & ~tr_hit) | (tr_sign & tr_hit);
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tr_ev_q <= 3'h0;
      tr_pol_q <= 3'h0;
    end else if (ce) begin
      tr_ev_q <= tr_ev_d;
      tr_pol_q <= tr_pol_d;
    end
  end

endmodule // iedd_top

// file: pkg/iedd_defs.vh
`ifndef IEDD_DEFS_VH
`define IEDD_DEFS_VH

// ********************************************************
// register indices, byte address is four times the index
// ********************************************************
`define IEDD_IDX_MOT_THS 8'h17
`define IEDD_IDX_MOT_CNT 8'h18
`define IEDD_IDX_TR_CFG 8'h1d
`define IEDD_IDX_TR_SRC 8'h1e
`define IEDD_IDX_CTRL 8'h2a
`define IEDD_IDX_MODE 8'h30
`define IEDD_IDX_MOT_AXIS 8'h31
`define IEDD_IDX_TR_THS 8'h32
`define IEDD_IDX_MOT_STAT 8'h33

// ********************************************************
// field positions
// ********************************************************
`define IEDD_THS_MODE_BIT 7
`define IEDD_TCFG_LATCH_BIT 4
`define IEDD_TCFG_BYP_BIT 0
`define IEDD_TSRC_EA_BIT 6
`define IEDD_CTRL_LN_BIT 0
`define IEDD_CTRL_ODR_LSB 3
`define IEDD_AXIS_OR_BIT 3
`define IEDD_MODE_FS_LSB 2
`define IEDD_STAT_FLAG_BIT 8

// ********************************************************
// reset values
// ********************************************************
`define IEDD_RST_BYTE 8'h00
`define IEDD_RST_WORD 32'h0000_0000

// ********************************************************
// oversampling modes and full-scale codes
// ********************************************************
`define IEDD_OS_NORMAL 2'h0
`define IEDD_OS_LOW_NOISE_LOW_POWER_MODE 2'h1
`define IEDD_OS_HIRES 2'h2
`define IEDD_OS_LP 2'h3
`define IEDD_FS_2G 2'h0
`define IEDD_FS_4G 2'h1

// ********************************************************
// thresholds and timing
// ********************************************************
// 4 g at 1/16 g per count
`define IEDD_THS_LN_CAP 7'h40
`define IEDD_CLK_PERIOD_NS 8
// shortest debounce step, 1.25 ms
`define IEDD_STEP_BASE_NS 1250000

`endif

// file: logic/iedd_step_timer.v
`timescale 1ns/1ps
`include "iedd_defs.vh"

module iedd_step_timer #(
  parameter BASE_CYCLES = `IEDD_STEP_BASE_NS / `IEDD_CLK_PERIOD_NS,
  parameter CNT_W = 25
) (
  input wire clock,
  input wire rst_b,
  input wire ce,
  input wire [2:0] output_data_rate,
  input wire [1:0] mode,
  output reg step_q
);

  // ********************************************************
  // step length as a power-of-two multiple of 1.25 ms
  // ********************************************************
  function [2:0] iedd_step_shift;
    input [2:0] rate;
    input [1:0] os;
    begin
      case (os)
        `IEDD_OS_HIRES: iedd_step_shift = (rate > 3'h1) ? 3'h1 : rate;
        `IEDD_OS_LOW_NOISE_LOW_POWER_MODE: iedd_step_shift = (rate > 3'h4) ? 3'h6 : rate;
        `IEDD_OS_LP: begin
          if (rate > 3'h5) begin
            iedd_step_shift = 3'h7;
          end else begin
            iedd_step_shift = (rate == 3'h5) ? 3'h6 : rate;
          end
        end
        default: iedd_step_shift = (rate > 3'h4) ? 3'h4 : rate;
      endcase
    end
  endfunction

  wire [CNT_W-1:0] base = BASE_CYCLES[CNT_W-1:0];
  wire [CNT_W-1:0] limit = base << iedd_step_shift(output_data_rate, mode);
  reg [CNT_W-1:0] cnt_q;

  // mode change takes effect at once: the live limit is compared every cycle, so a step can end early
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= {CNT_W{1'b0}};
      step_q <= 1'b0;
    end else if (ce) begin
      if (cnt_q >= limit - 1'b1) begin
        cnt_q <= {CNT_W{1'b0}};
        step_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
        step_q <= 1'b0;
      end
    end
  end

endmodule // iedd_step_timer

// file: logic/iedd_debounce.v
`timescale 1ns/1ps
`include "iedd_defs.vh"

module iedd_debounce #(
  parameter W = 8
) (
  input wire clock,
  input wire rst_b,
  input wire ce,
  input wire step,
  input wire cond,
  input wire clear_mode,
  input wire [W-1:0] limit,
  output reg [W-1:0] cnt_q,
  output reg flag_q
);

  reg [W-1:0] cnt_d;

  always @* begin
    if (cond) begin
      cnt_d = (cnt_q < limit) ? cnt_q + 1'b1 : limit;
    end else if (clear_mode) begin
      cnt_d = {W{1'b0}};
    end else begin
      cnt_d = (cnt_q != {W{1'b0}}) ? cnt_q - 1'b1 : cnt_q;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= {W{1'b0}};
      flag_q <= 1'b0;
    end else if (ce && step) begin
      cnt_q <= cnt_d;
      flag_q <= cond && (cnt_d == limit);
    end
  end

endmodule // iedd_debounce

// file: sim/iedd_chk_sva.sv
`timescale 1ns/1ps
module iedd_chk #(
  parameter ADDR_W = 10
) (
  input wire clock,
  input wire rst_b,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire sample_valid,
  input wire motion_event,
  input wire transient_event
);
  wire [7:0] idx = paddr[9:2];
  wire mapped = idx == 8'h17 || idx == 8'h18 || idx == 8'h1d || idx == 8'h1e || idx == 8'h2a ||
    (idx >= 8'h30 && idx <= 8'h33);
  wire src_rd = pready && !pwrite && idx == 8'h1e;
  // enables can drop the active flag, so a config write counts as a cause too
  wire cfg_wr = pready && pwrite && idx == 8'h1d;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_src_rd;
    src_rd;
  endsequence
  sequence s_no_sample;
    !sample_valid && !$past(sample_valid);
  endsequence
  a_ready_access: assert property (pready == (psel && penable && ce))
    else $error("pready not tied to access");
  a_err_idle: assert property (!pready |-> !pslverr) else $error("pslverr outside access");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr) else $error("no error on hole");
  a_mapped_ok: assert property (pready && mapped |-> !pslverr) else $error("error on register");
  a_reset_quiet: assert property ($rose(rst_b) |-> !motion_event && !transient_event)
    else $error("event after reset");
  a_src_clear: assert property (s_src_rd ##0 s_no_sample |=> !transient_event)
    else $error("source read left event set");
  a_event_sticky: assert property ($fell(transient_event) |-> $past(src_rd) || $past(cfg_wr))
    else $error("event dropped without read");
  a_event_cause: assert property ($rose(transient_event) |->
    $past(sample_valid) || $past(sample_valid, 2) || $past(cfg_wr))
    else $error("event rose without sample");
  a_ce_freeze: assert property (!ce |=> $stable(motion_event) && $stable(transient_event))
    else $error("state moved while frozen");
endmodule // iedd_chk

bind iedd_top iedd_chk #(.ADDR_W(ADDR_W)) chk_u (.clock, .rst_b, .ce, .psel, .penable, .pwrite,
  .paddr, .pready, .pslverr, .sample_valid, .motion_event, .transient_event);

// file: sim/iedd_tb.sv
`timescale 1ns/1ps
module tb;
  logic clock = 0, rst_b = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, sample_valid = 0;
  logic [9:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [13:0] accel_x = 0, accel_y = 0, accel_z = 0, hpf_x = 0, hpf_y = 0, hpf_z = 0;
  logic err;
  wire [31:0] prdata;
  wire pready, pslverr, motion_event, transient_event;
  integer errors = 0, checked = 0, cycles = 0, i, m, n;
  integer src_m = 0, cfg_m = 0, ths_m = 0, fs_m = 0, ln_m = 0;
  logic [7:0] rlist [4] = '{8'h17, 8'h18, 8'h1d, 8'h1e};
  always #4 clock = ~clock;
  // short step so debounce runs in tens of cycles
  iedd_top #(.STEP_BASE_CYCLES(10)) dut_u (.clock, .rst_b, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sample_valid, .accel_x, .accel_y, .accel_z, .hpf_x,
    .hpf_y, .hpf_z, .motion_event, .transient_event);
  // ********************************************************
  // report and bus tasks
  // ********************************************************
  task end_sim;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      end_sim();
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input [7:0] idx, input [31:0] wd);
    integer k;
    psel <= 1; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= wd; penable <= 0;
    @(posedge clock);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clock);
  endtask
  task rdc(input [7:0] idx, input [31:0] exp);
    apb(0, idx, 0);
    chk(rd, exp);
  endtask
  task rdsrc;
    rdc(8'h1e, src_m);
    src_m = 0;
  endtask
  // ********************************************************
  // transient model
  // ********************************************************
  function integer mag(input [13:0] s);
    mag = (s[13] ? 16384 - s : s) >> (fs_m == 0 ? 8 : fs_m == 1 ? 7 : 6);
  endfunction
  task smp(input [41:0] a, input [41:0] h);
    integer k, lim;
    logic [13:0] s;
    {accel_z, accel_y, accel_x} <= a; {hpf_z, hpf_y, hpf_x} <= h; sample_valid <= 1;
    @(posedge clock);
    sample_valid <= 0;
    lim = (ln_m == 1 && ths_m > 64) ? 64 : ths_m;
    if (!(cfg_m[4] && src_m[6])) for (k = 0; k < 3; k++) begin
      s = cfg_m[0] ? a[14*k +: 14] : h[14*k +: 14];
      if (cfg_m[k+1] && mag(s) > lim)
        src_m = (src_m & ~(3 << 2*k)) | (2 << 2*k) | (s[13] << 2*k);
    end
    if (src_m & 8'h2a) src_m = src_m | 8'h40;
    repeat (3) @(posedge clock);
  endtask
  // ********************************************************
  // sequence
  // ********************************************************
  initial begin
    i = $urandom(32'h33d7);
    repeat (16) @(posedge clock);
    rst_b <= 1;
    @(posedge clock);
    for (i = 0; i < 4; i++) rdc(rlist[i], 0);
    apb(0, 8'h00, 0);
    chk(err, 1);
    chk(rd, 0);
    for (i = 0; i < 4; i++) begin
      n = $urandom & 255;
      apb(1, 8'h18, n);
      rdc(8'h18, n);
    end
    apb(1, 8'h32, 16); ths_m = 16;
    apb(1, 8'h1d, 2); cfg_m = 2;
    smp({28'h0, 14'h1800}, 0);
    rdsrc;
    apb(1, 8'h1d, 3); cfg_m = 3;
    smp({28'h0, 14'h1800}, 0);
    chk(transient_event, 1);
    smp({14'h0, 14'h2800, 14'h0010}, 0);
    chk(transient_event, 1);
    apb(1, 8'h1d, 8'h0f); cfg_m = 15;
    smp({14'h0, 14'h2800, 14'h0010}, 0);
    rdsrc;
    rdsrc;
    apb(1, 8'h1d, 8'h1f); cfg_m = 31;
    smp({28'h0, 14'h1800}, 0);
    smp({14'h2800, 28'h0}, 0);
    rdsrc;
    apb(1, 8'h30, 8'h08); fs_m = 2;
    apb(1, 8'h32, 8'h7f); ths_m = 127;
    apb(1, 8'h1d, 3); cfg_m = 3;
    for (m = 0; m < 2; m++) begin
      apb(1, 8'h2a, m); ln_m = m;
      smp({28'h0, 14'h1400}, 0);
      rdsrc;
    end
    apb(1, 8'h2a, 0); ln_m = 0;
    apb(1, 8'h30, 0); fs_m = 0;
    apb(1, 8'h32, 16); ths_m = 16;
    ce <= 0;
    repeat (5) @(posedge clock);
    ce <= 1;
    @(posedge clock);
    apb(1, 8'h31, 9);
    apb(1, 8'h18, 3);
    for (m = 0; m < 2; m++) begin
      apb(1, 8'h17, m ? 8'h10 : 8'h90);
      smp({28'h0, 14'h1800}, 0);
      n = 0;
      do begin apb(0, 8'h33, 0); n++; end while (rd[8] !== 1'b1 && n < 40);
      chk(rd, 32'h103);
      chk(motion_event, 1);
      repeat (30) @(posedge clock);
      rdc(8'h33, 32'h103);
      smp(0, 0);
      n = 0;
      do begin apb(0, 8'h33, 0); n++; end while (rd[7:0] === 8'h03 && n < 40);
      chk(rd[7:0], m ? 2 : 0);
    end
    rdsrc;
    end_sim();
  end
endmodule // tb
